// ==== src/lsc_consts.vh ====
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH
// frame identifier indices
`define LSC_ID_WR_NODE     6'h01
`define LSC_ID_WR_GROUP    6'h02
`define LSC_ID_OTP_DUMP    6'h08
`define LSC_ID_QUICK_STAT  6'h09
`define LSC_ID_BACKEMF     6'h0A
// command codes and addressing
`define LSC_CMD_GOTO_SAFE  8'h04
`define LSC_CMD_STOP       8'h05
`define LSC_NAD_BROADCAST  8'h7F
// otp locations used by the dump
`define LSC_OTP_ALT_LO     4'h8
`define LSC_OTP_ALT_HI     4'h9
// apb register byte addresses
`define LSC_REG_CTRL       8'h00
`define LSC_REG_SAFE_POS   8'h04
`define LSC_REG_FLAGS      8'h08
`define LSC_REG_IRQ_STAT   8'h0C
`define LSC_REG_IRQ_MASK   8'h10
`define LSC_REG_POSITION   8'h14
// ctrl fields
`define LSC_CTRL_NAD_MSB   7
`define LSC_CTRL_MEMSEL    8
`define LSC_CTRL_SAFE_EN   9
`define LSC_CTRL_RESET     10'h000
// interrupt event bits
`define LSC_EV_GOTO        0
`define LSC_EV_STOP        1
`define LSC_EV_READ        2
`define LSC_EV_IGNORED     3
`define LSC_EV_W           4
`endif

// ==== src/lsc_top.v ====
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "lsc_consts.vh"

module lsc_top #(
  parameter OTP_BYTES = 10
) (
  // clock, reset, enable
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   ce,
  // apb slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [7:0]             paddr,
  input  wire [31:0]            pwdata,
  output wire                   pready,
  output reg  [31:0]            prdata,
  output wire                   pslverr,
  output wire                   irq,
  // frames from the link layer, checksum already checked
  input  wire                   rd_req,
  input  wire [5:0]             rd_id,
  input  wire                   wf_valid,
  input  wire [5:0]             wf_id,
  input  wire [7:0]             wf_byte1,
  input  wire [7:0]             wf_byte2,
  input  wire                   full_status_read,
  // response towards the link layer
  output reg                    rsp_valid_q,
  output reg  [3:0]             rsp_len_q,
  output reg  [63:0]            rsp_data_q,
  // node state inputs
  input  wire [8*OTP_BYTES-1:0] otp_bytes,
  input  wire                   motion_switch_state,
  input  wire [1:0]             temp_info,
  input  wire                   tw_cause,
  input  wire                   tsd_cause,
  input  wire                   uv_cause,
  input  wire                   uv2_cause,
  input  wire                   uv3_cause,
  input  wire                   coil_open_cause,
  input  wire                   coil_short_cause,
  input  wire                   bemf_valid,
  input  wire                   bemf_full_duty,
  input  wire                   bemf_coil_y,
  input  wire [4:0]             bemf_value,
  input  wire                   lin_lost,
  input  wire                   init_done,
  input  wire                   sleep_request,
  input  wire                   motor_moving,
  input  wire [15:0]            actual_position,
  // motion control outputs
  output reg                    goto_safe_q,
  output reg                    stop_q,
  output reg                    shutdown_q,
  output reg  [15:0]            target_position_q,
  output reg                    target_load_q
);

  // ****************************************
  // state
  // ****************************************
  reg  [9:0]              ctrl_q;
  reg  [10:0]             safe_pos_q;
  reg  [`LSC_EV_W-1:0]    irq_stat_q;
  reg  [`LSC_EV_W-1:0]    irq_mask_q;
  reg  [6:0]              flags_q;     // step, coil, uv, tsd, tw, uv2, uv3
  reg                     short_seen_q;
  reg                     coil_prev_q;
  reg                     copy_pend_q;
  reg  [7:0]              bemf_q;

  // ctrl_q: node address [6:0], memory select [8], safe enable [9]
  // safe_pos_q: the 11-bit park target that every goto loads, unless a pending copy in the same cycle overrides it
  // irq_stat_q: goto issued, stop issued, read served, foreign write
  // short_seen_q: remembers a coil short until the complete status read
  // coil_prev_q: makes the coil stop edge-triggered, so a lasting fault
  // does not re-issue a stop in every cycle
  // copy_pend_q: waits for the motor to rest after a stop
  // bemf_q: last back-emf answer byte, bit 7 always set

  // otp image split into bytes; only locations 0..9 are ever read

  wire [7:0] otp_loc [0:OTP_BYTES-1];
  genvar gi;
  generate
    for (gi = 0; gi < OTP_BYTES; gi = gi + 1) begin : g_otp
      assign otp_loc[gi] = otp_bytes[8*gi+7:8*gi];
    end
  endgenerate

  // ****************************************
  // write-frame decode
  // ****************************************
  wire       wr_node  = wf_valid && (wf_id == `LSC_ID_WR_NODE);
  wire       wr_group = wf_valid && (wf_id == `LSC_ID_WR_GROUP);
  wire       nad_hit  = (wf_byte1 == {1'b0, ctrl_q[`LSC_CTRL_NAD_MSB-1:0]}) ||
                        (wf_byte1 == `LSC_NAD_BROADCAST);
  // the command byte sits after the address only in the node frame
  wire [7:0] wr_cmd   = wr_node ? wf_byte2 : wf_byte1;
  wire       wr_take  = wr_group || (wr_node && nad_hit);
  wire       wr_skip  = wr_node && !nad_hit;
  wire       cmd_stop = wr_take && (wr_cmd == `LSC_CMD_STOP);
  wire       cmd_goto = wr_take && (wr_cmd == `LSC_CMD_GOTO_SAFE);

  // electrical fault edge forces a stop into shutdown
  wire       coil_any  = coil_open_cause || coil_short_cause;
  wire       coil_rise = coil_any && !coil_prev_q;
  wire       stop_now  = cmd_stop || coil_rise;
  // priority: a stop or shutdown beats every goto request
  wire       goto_req  = cmd_goto || lin_lost || init_done || sleep_request;
  wire       goto_now  = goto_req && !stop_now && !shutdown_q;


  // read header decode; unknown ids are dropped without an answer
  wire       rd_quick  = rd_req && (rd_id == `LSC_ID_QUICK_STAT);
  wire       rd_any    = rd_req && ((rd_id == `LSC_ID_OTP_DUMP) || rd_quick ||
                                    (rd_id == `LSC_ID_BACKEMF));

  // ****************************************
  // apb slave, zero wait
  // ****************************************
  wire       apb_wr = psel && penable && pwrite;
  wire       mapped = (paddr == `LSC_REG_CTRL) || (paddr == `LSC_REG_SAFE_POS) ||
                      (paddr == `LSC_REG_FLAGS) || (paddr == `LSC_REG_IRQ_STAT) ||
                      (paddr == `LSC_REG_IRQ_MASK) || (paddr == `LSC_REG_POSITION);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq     = |(irq_stat_q & irq_mask_q);

  reg [31:0] rd_mux;
  // read mux, captured in the setup cycle so prdata comes from a flop
  always @* begin
    case (paddr)
      `LSC_REG_CTRL:     rd_mux = {22'h000000, ctrl_q};
      `LSC_REG_SAFE_POS: rd_mux = {21'h000000, safe_pos_q};
      `LSC_REG_FLAGS:    rd_mux = {24'h000000, shutdown_q, flags_q};
      `LSC_REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
      `LSC_REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
      `LSC_REG_POSITION: rd_mux = {target_position_q, actual_position};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end


  // limitation: a write to a read-only offset is dropped silently
  // and still ends without error, since the offset is mapped
  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `LSC_CTRL_RESET;
      safe_pos_q <= 11'h000;
      irq_mask_q <= 4'h0;
    end else if (ce && apb_wr) begin
      if (paddr == `LSC_REG_CTRL)
        ctrl_q <= pwdata[9:0];
      if (paddr == `LSC_REG_SAFE_POS)
        safe_pos_q <= pwdata[10:0];
      if (paddr == `LSC_REG_IRQ_MASK)
        irq_mask_q <= pwdata[`LSC_EV_W-1:0];
    end
  end


  // sticky events, a new event wins over a write-one clear
  // so that an event in the clearing cycle is never lost
  wire [`LSC_EV_W-1:0] ev_set = {wr_skip, rd_any, stop_now, goto_now};
  wire [`LSC_EV_W-1:0] ev_clr = (apb_wr && paddr == `LSC_REG_IRQ_STAT) ?
                                pwdata[`LSC_EV_W-1:0] : 4'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 4'h0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
    end
  end

  // ****************************************
  // fault flags
  // ****************************************
  wire [6:0] causes = {1'b0, coil_any, uv_cause, tsd_cause, tw_cause, uv2_cause, uv3_cause};
  reg  [6:0] flags_d;
  reg        short_d;

  // clear first, then set: a persisting cause keeps its flag
  // the complete status read clears everything, the short memory too;
  // the quick read spares the coil flag while a short is remembered
  // step lost is set last, so a stop in a clearing read still shows
  always @* begin
    flags_d = flags_q;
    short_d = short_seen_q;
    if (full_status_read) begin
      flags_d = 7'h00;
      short_d = 1'b0;
    end else if (rd_quick) begin
      flags_d = 7'h00;
      flags_d[5] = short_seen_q;
    end
    if (coil_short_cause)
      short_d = 1'b1;
    flags_d = flags_d | causes;
    if (stop_now && motor_moving)
      flags_d[6] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q      <= 7'h00;
      short_seen_q <= 1'b0;
      coil_prev_q  <= 1'b0;
    end else if (ce) begin
      flags_q      <= flags_d;
      short_seen_q <= short_d;
      coil_prev_q  <= coil_any;
    end
  end


  // latest back-emf measurement
  // reset value reads as coil x, zero result, marker bit set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bemf_q <= 8'h80;
    end else if (ce && bemf_valid) begin
      bemf_q <= {1'b1, bemf_full_duty, bemf_coil_y, bemf_value};
    end
  end

  // ****************************************
  // read responses
  // ****************************************
  wire       memsel  = ctrl_q[`LSC_CTRL_MEMSEL];
  wire [7:0] dump6   = memsel ? otp_loc[`LSC_OTP_ALT_LO] : otp_loc[5];
  wire [7:0] dump7   = memsel ? otp_loc[`LSC_OTP_ALT_HI] : otp_loc[6];

  // status byte shows the flags as they stood before this read clears them
  // trade-off: the answer is registered, one cycle after the header,
  // so the link layer must allow one cycle before the first data byte
  wire [7:0] quick_b = {motion_switch_state, flags_q[6:2], temp_info};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_len_q   <= 4'h0;
      rsp_data_q  <= 64'h0000000000000000;
    end else if (ce) begin
      rsp_valid_q <= rd_any;
      if (rd_req) begin
        case (rd_id)
          `LSC_ID_OTP_DUMP: begin
            rsp_len_q  <= 4'h8;
            rsp_data_q <= {otp_loc[7], dump7, dump6, otp_loc[4], otp_loc[3],
                           otp_loc[2], otp_loc[1], otp_loc[0]};
          end
          `LSC_ID_QUICK_STAT: begin
            rsp_len_q  <= 4'h1;
            rsp_data_q <= {56'h00000000000000, quick_b};
          end
          `LSC_ID_BACKEMF: begin
            rsp_len_q  <= 4'h1;
            rsp_data_q <= {56'h00000000000000, bemf_q};
          end
          default: begin
            rsp_len_q  <= 4'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // motion commands
  // ****************************************

  // a stop and a goto in one cycle: the stop wins and the goto is lost,
  // the safe choice for a node that may be stalled or faulty
  // hazard: the copy of actual into target waits for rest, because a
  // copy taken while still slowing down would park short of the motor
  // a goto in the same cycle as a pending copy is overridden by the copy
  // shutdown stays until a full status read and no coil fault remains
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      goto_safe_q       <= 1'b0;
      stop_q            <= 1'b0;
      shutdown_q        <= 1'b0;
      copy_pend_q       <= 1'b0;
      target_load_q     <= 1'b0;
      target_position_q <= 16'h0000;
    end else if (ce) begin
      goto_safe_q   <= goto_now;
      stop_q        <= stop_now;
      target_load_q <= 1'b0;
      if (coil_rise)
        shutdown_q <= 1'b1;
      else if (full_status_read && !coil_any)
        shutdown_q <= 1'b0;
      if (goto_now) begin
        // safe_position_enable is deliberately not consulted here
        target_position_q <= {5'h00, safe_pos_q};
        target_load_q     <= 1'b1;
      end
      if (stop_now) begin
        copy_pend_q <= 1'b1;
      end else if (copy_pend_q && !motor_moving) begin
        copy_pend_q       <= 1'b0;
        target_position_q <= actual_position;
        target_load_q     <= 1'b1;
      end
    end
  end

endmodule

// ==== bench/lsc_assertions.sv ====
`timescale 1ns/1ps
// ******************
// lsc command checks
// ******************
module lsc_assertions #(
  parameter OTP_BYTES = 10
) (
  // clock, reset, enable
  input wire                   pclk,
  input wire                   presetn,
  input wire                   ce,
  // frames from the link side
  input wire                   rd_req,
  input wire [5:0]             rd_id,
  input wire                   wf_valid,
  input wire [5:0]             wf_id,
  input wire [7:0]             wf_byte1,
  input wire [7:0]             wf_byte2,
  input wire                   lin_lost,
  // answers and node state
  input wire                   rsp_valid_q,
  input wire [3:0]             rsp_len_q,
  input wire [63:0]            rsp_data_q,
  input wire [8*OTP_BYTES-1:0] otp_bytes,
  input wire                   motion_switch_state,
  input wire [1:0]             temp_info,
  input wire                   coil_open_cause,
  input wire                   coil_short_cause,
  input wire                   goto_safe_q,
  input wire                   stop_q,
  input wire                   shutdown_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // calm: no coil event or shutdown that could veto a move
  wire rd = rd_req && ce;
  wire wf = wf_valid && ce;
  wire calm = !shutdown_q && !coil_open_cause && !coil_short_cause;
  AST_DUMP: assert property (rd && rd_id == 6'h08 |=> rsp_valid_q && rsp_len_q == 4'h8 &&
    rsp_data_q[39:0] == $past(otp_bytes[39:0]) && rsp_data_q[63:56] == $past(otp_bytes[63:56]))
    else $error("dump answer wrong");
  AST_QUICK: assert property (rd && rd_id == 6'h09 |=> rsp_valid_q && rsp_len_q == 4'h1 &&
    rsp_data_q[7] == $past(motion_switch_state) && rsp_data_q[1:0] == $past(temp_info))
    else $error("quick status answer wrong");
  AST_BEMF: assert property (rd && rd_id == 6'h0A |=> rsp_valid_q && rsp_len_q == 4'h1 &&
    rsp_data_q[7]) else $error("back-emf answer wrong");
  AST_COIL_STOP: assert property ($rose(coil_open_cause || coil_short_cause)
    |-> ##[1:2] stop_q ##[0:2] shutdown_q) else $error("coil fault without stop");
  AST_STOP_BCAST: assert property (wf && wf_id == 6'h01 && wf_byte1 == 8'h7F &&
    wf_byte2 == 8'h05 |=> stop_q) else $error("broadcast stop missed");
  AST_STOP_GRP: assert property (wf && wf_id == 6'h02 && wf_byte1 == 8'h05 |=> stop_q)
    else $error("group stop missed");
  AST_GOTO_GRP: assert property (wf && wf_id == 6'h02 && wf_byte1 == 8'h04 && calm &&
    $past(calm) |=> goto_safe_q) else $error("group goto missed");
  AST_GOTO_INT: assert property (lin_lost && ce && !wf_valid && calm && $past(calm)
    |=> goto_safe_q) else $error("link loss goto missed");
  cover property (rd && rd_id == 6'h09);
  cover property (wf && wf_id == 6'h02);
  cover property (goto_safe_q);
endmodule

// ==== bench/lsc_lin_master.sv ====
`timescale 1ns/1ps
// *************
// link master
// *************
module lsc_lin_master (
  // clock
  input  wire       pclk,
  // frame strobes
  output reg        rd_req = 1'b0,
  output reg  [5:0] rd_id = 6'h3F,
  output reg        wf_valid = 1'b0,
  output reg  [5:0] wf_id = 6'h3F,
  output reg  [7:0] wf_byte1 = 8'hAA,
  output reg  [7:0] wf_byte2 = 8'h55
);
  // header of a reading frame; id scrambled after so stale ids never match
  task automatic read_frame(input logic [5:0] id);
    @(posedge pclk);
    rd_req <= 1'b1;
    rd_id <= id;
    @(posedge pclk);
    rd_req <= 1'b0;
    rd_id <= ~id;
  endtask
  // node frame: address then code; group frame: code first, no address
  task automatic write_frame(input logic [5:0] id, input logic [7:0] b1, b2);
    @(posedge pclk);
    wf_valid <= 1'b1;
    wf_id <= id;
    wf_byte1 <= b1;
    wf_byte2 <= (id == 6'h02) ? ~b1 : b2;
    @(posedge pclk);
    wf_valid <= 1'b0;
    wf_byte1 <= ~b1;
    wf_byte2 <= ~b2;
  endtask
endmodule

// ==== bench/lsc_top_test.sv ====
`timescale 1ns/1ps
// *************
// lsc bench top
// *************
module lsc_top_test;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic        pready, pslverr, irq, perr, rsp_valid_q, goto_safe_q, stop_q, shutdown_q;
  logic        target_load_q, motion_switch_state = 0, uv_cause = 0, tsd_cause = 0;
  logic        uv3_cause = 0, bemf_full_duty = 0, bemf_coil_y = 0, motor_moving = 0;
  logic        full_status_read, coil_open_cause, coil_short_cause, tw_cause, uv2_cause;
  logic        bemf_valid, lin_lost, init_done, sleep_request;
  logic [1:0]  temp_info = 0;
  logic [3:0]  rsp_len_q;
  logic [4:0]  bemf_value = 0;
  logic [10:0] spos;
  logic [15:0] actual_position = 0, target_position_q;
  logic [63:0] rsp_data_q;
  logic [79:0] otp_bytes = 0;
  logic [8:0]  ev = 0;
  wire         rd_req, wf_valid;
  wire  [5:0]  rd_id, wf_id;
  wire  [7:0]  wf_byte1, wf_byte2;
  logic [23:0] tbl [7];
  logic [67:0] expq [$];
  int          seed = 32'hd380, mismatches = 0, checks = 0, cycles = 0;
  // one-cycle event inputs share one vector
  assign {lin_lost, init_done, sleep_request, full_status_read, coil_open_cause,
          coil_short_cause, tw_cause, uv2_cause, bemf_valid} = ev;
  lsc_top i_dut (.*);
  lsc_lin_master i_master (.*);
  always #10 pclk = ~pclk;
  // runaway guard; the sequence needs about 110 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  // answer watcher; upper bytes of one-byte answers are not compared
  always @(posedge pclk) begin
    if (rsp_valid_q === 1'b1) begin
      if (expq.size() == 0) chk(1, 0, "stray answer");
      else chk({rsp_len_q, rsp_len_q == 4'h8 ? rsp_data_q[63:8] : 56'h0, rsp_data_q[7:0]},
               expq.pop_front(), "answer");
    end
  end
  task automatic chk(input logic [67:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; the wait is bounded by the runaway guard
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 9'h000;
  endtask
  task automatic quick(input logic [4:0] f);
    expq.push_back({4'h1, 56'h0, motion_switch_state, f, temp_info});
    i_master.read_frame(6'h09);
  endtask
  // main sequence
  initial begin
    tbl = '{24'h811505, 24'h417F04, 24'h011605, 24'h8205A5, 24'h42045A, 24'h011503,
            24'h817F05};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 10; k++) otp_bytes[8*k +: 8] <= 8'($random(seed));
    motion_switch_state <= 1'($random(seed));
    temp_info <= 2'($random(seed));
    actual_position <= 16'($random(seed));
    spos = 11'($random(seed));
    apb(1'b1, 8'h04, {21'h0, spos});
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h00, {22'h0, 1'b0, m[0], 8'h15});
      expq.push_back({4'h8, otp_bytes[63:56], m ? otp_bytes[79:64] : otp_bytes[55:40],
                      otp_bytes[39:0]});
      i_master.read_frame(6'h08);
    end
    uv_cause <= 1'b1;
    pulse(9'h006);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat[7:0], 8'h16, "flags set");
    quick(5'b00101);
    quick(5'b00100);
    uv_cause <= 1'b0;
    quick(5'b00100);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat[7:0], 8'h00, "flags cleared");
    pulse(9'h008);
    repeat (3) @(posedge pclk);
    chk(shutdown_q, 1, "shutdown");
    quick(5'b01000);
    quick(5'b01000);
    pulse(9'h020);
    pulse(9'h010);
    quick(5'b01000);
    quick(5'b00000);
    pulse(9'h020);
    for (int c = 0; c < 2; c++) begin
      bemf_full_duty <= 1'($random(seed));
      bemf_coil_y <= c[0];
      bemf_value <= 5'($random(seed));
      pulse(9'h001);
      expq.push_back({4'h1, 56'h0, 1'b1, bemf_full_duty, bemf_coil_y, bemf_value});
      i_master.read_frame(6'h0A);
    end
    apb(1'b1, 8'h10, 32'h8);
    #1 chk(irq, 0, "irq masked");
    for (int i = 0; i < 7; i++) begin
      i_master.write_frame(tbl[i][21:16], tbl[i][15:8], tbl[i][7:0]);
      #1 chk({stop_q, goto_safe_q}, tbl[i][23:22], "write");
      if (tbl[i][22]) chk(target_position_q, {5'h0, spos}, "safe target");
      if (tbl[i][22]) chk(target_load_q, 1, "target load");
    end
    chk(irq, 1, "ignored frame irq");
    apb(1'b1, 8'h0C, 32'h8);
    #1 chk(irq, 0, "irq cleared");
    apb(1'b0, 8'h40, 32'h0);
    chk({perr, rdat}, {1'b1, 32'h0}, "unmapped");
    motor_moving <= 1'b1;
    i_master.write_frame(6'h02, 8'h05, 8'h00);
    motor_moving <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(target_position_q, actual_position, "stop hold");
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat[6], 1, "step lost");
    for (int k = 0; k < 3; k++) begin
      pulse(9'h100 >> k);
      #1 chk(goto_safe_q, 1, "internal goto");
    end
    // frozen enable: this header must be lost, the watcher flags any answer
    ce <= 1'b0;
    i_master.read_frame(6'h09);
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(expq.size(), 0, "answers missing");
    wrap_up();
  end
endmodule
bind lsc_top lsc_assertions #(.OTP_BYTES(OTP_BYTES)) i_chk (.*);
